// ---- src/ssp_consts.svh ----
// Width, field and reset constants for the burst memory port
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

`define SSP_ADDR_W      19
`define SSP_LANES       2
`define SSP_BYTE_W      8
`define SSP_LANE_W      9
`define SSP_WORD_W      18
`define SSP_DATA_W      16
`define SSP_DEPTH       524288
`define SSP_BEAT_W      2
`define SSP_BASE_LSB    2
`define SSP_BEAT_RST    2'h0
`define SSP_START_RST   2'h0
`define SSP_BASE_RST    17'h00000
`define SSP_WORD_RST    18'h00000
`define SSP_LANES_NONE  2'h0
`define SSP_LANES_ALL   2'h3

`endif

// ---- src/ssp_mem.sv ----
// Storage array with per-lane write enables and a registered read port
`timescale 1ns/10ps
`include "ssp_consts.svh"

module ssp_mem (
    // Clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_resetn,
    // Write port
    input  wire logic [`SSP_LANES-1:0]    i_wr_lanes,
    input  wire logic [`SSP_ADDR_W-1:0]   i_wr_addr,
    input  wire logic [`SSP_WORD_W-1:0]   i_wr_word,
    // Read port
    input  wire logic [`SSP_ADDR_W-1:0]   i_rd_addr,
    output logic      [`SSP_WORD_W-1:0]   o_rd_word
);

    logic [`SSP_WORD_W-1:0] mem_r [0:`SSP_DEPTH-1];
    logic [`SSP_WORD_W-1:0] rd_word_r;

    // Lane-wise write, contents are never cleared by reset
    always_ff @(posedge i_clk) begin
        for (int l = 0; l < `SSP_LANES; l++) begin
            if (i_wr_lanes[l]) begin
                mem_r[i_wr_addr][l*`SSP_LANE_W +: `SSP_LANE_W]
                    <= i_wr_word[l*`SSP_LANE_W +: `SSP_LANE_W];
            end
        end
    end

    // Read word registered at the edge that sets the address
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_word_r <= `SSP_WORD_RST;
        end else begin
            rd_word_r <= mem_r[i_rd_addr];
        end
    end

    assign o_rd_word = rd_word_r;

endmodule

// ---- src/ssp_pkg.sv ----
// Types shared by the burst memory port
package ssp_pkg;

    // Access state of the port
    typedef enum logic {
        SSP_DESELECTED,
        SSP_SELECTED
    } ssp_state_t;

    // Order of beats inside one burst
    typedef enum logic {
        SSP_ORDER_LINEAR,
        SSP_ORDER_INTERLEAVED
    } ssp_order_t;

endpackage

// ---- src/ssp_port.sv ----
// Synchronous flow-through burst memory port, pin-level device logic
`timescale 1ns/10ps
`include "ssp_consts.svh"

// How it works
// - Burst counter steps only when advance is low during an active burst.
// - Processor strobe loads nothing when the first select is high, yet still blocks the controller strobe.
// - Selects are looked at only on address load edges, not burst steps.
// - Selected only when first low, second high, third low together.
// - Data pins drive the clock after output enable is seen low, float the clock after it is high.
// - Output enable is masked on the first read clock after deselection.
// - Advance low inside a burst moves access to the next burst address.
// - Accepted strobe loads full address, keeps low two bits as burst start and clears counter.
// - With both strobes low only the processor strobe is acted on.
// - Sleep high idles the port and keeps contents; low runs normally.
// - Pin values are captured into storage at the rising edge on writes.
// - Read data come out the cycle after the address edge, no extra stage.
// - Pins float on write data, first clock after deselection, deselected.
// - Parity pins behave as data, written under their own lane select.
// - Order strap low gives linear bursts, high gives interleaved bursts.
// - Global write low writes every lane regardless of byte gate and lane selects.
// - A lane is written when its select and the byte gate are both low.
// - Counter is two bits and wraps inside an aligned group of four.
module ssp_port (
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_resetn,
    // Address and burst control
    input  wire logic [`SSP_ADDR_W-1:0]    i_addr,
    input  wire logic                      i_proc_addr_strobe_n,
    input  wire logic                      i_ctrl_addr_strobe_n,
    input  wire logic                      i_burst_advance_n,
    // Selects
    input  wire logic                      i_select_first_n,
    input  wire logic                      i_select_second_hi,
    input  wire logic                      i_select_third_n,
    // Write controls
    input  wire logic                      i_all_bytes_write_n,
    input  wire logic                      i_byte_write_gate_n,
    input  wire logic [`SSP_LANES-1:0]     i_byte_lane_select_n,
    // Output enable, sleep and order strap
    input  wire logic                      i_out_enable_n,
    input  wire logic                      i_sleep_request,
    input  wire logic                      i_burst_order,
    // Data pins
    input  wire logic [`SSP_DATA_W-1:0]    i_dq,
    output logic      [`SSP_DATA_W-1:0]    o_dq,
    output logic                           o_dq_oe,
    // Parity pins
    input  wire logic [`SSP_LANES-1:0]     i_parity_pins,
    output logic      [`SSP_LANES-1:0]     o_parity_pins,
    output logic                           o_parity_pins_oe,
    // Sleep status
    output logic                           o_asleep
);

    // Registered port state
    ssp_pkg::ssp_state_t             state_r;
    ssp_pkg::ssp_state_t             state_nxt;
    logic [`SSP_ADDR_W-3:0]          base_r;
    logic [`SSP_ADDR_W-3:0]          base_nxt;
    logic [`SSP_BEAT_W-1:0]          start_r;
    logic [`SSP_BEAT_W-1:0]          start_nxt;
    logic [`SSP_BEAT_W-1:0]          beat_r;
    logic [`SSP_BEAT_W-1:0]          beat_nxt;
    logic                            oe_r;
    logic                            oe_nxt;
    logic                            asleep_r;
    logic                            asleep_nxt;

    // Decoded controls for this edge
    ssp_pkg::ssp_order_t             order;
    logic                            proc_load;
    logic                            ctrl_load;
    logic                            load;
    logic                            selected;
    logic                            wr_req;
    logic [`SSP_LANES-1:0]           wr_lanes;
    logic [`SSP_BEAT_W-1:0]          wr_beat;
    logic [`SSP_ADDR_W-1:0]          wr_addr;
    logic [`SSP_ADDR_W-1:0]          rd_addr;
    logic [`SSP_WORD_W-1:0]          wr_word;
    logic [`SSP_WORD_W-1:0]          rd_word;

    // Low address bits of a given beat of a burst
    function automatic logic [`SSP_BEAT_W-1:0] beat_bits(
        input ssp_pkg::ssp_order_t    ord,
        input logic [`SSP_BEAT_W-1:0] start,
        input logic [`SSP_BEAT_W-1:0] n
    );
        logic [`SSP_BEAT_W-1:0] res;
        if (ord == ssp_pkg::SSP_ORDER_INTERLEAVED) begin
            res = start ^ n;
        end else begin
            res = start + n;
        end
        return res;
    endfunction

    // Strap decode: high means interleaved, low means linear
    always_comb begin
        order = i_burst_order ? ssp_pkg::SSP_ORDER_INTERLEAVED
                              : ssp_pkg::SSP_ORDER_LINEAR;
    end

    // Strobe qualification and select decode
    always_comb begin
        proc_load = !i_proc_addr_strobe_n && !i_select_first_n;
        ctrl_load = !i_ctrl_addr_strobe_n
                    && i_proc_addr_strobe_n;
        load      = (proc_load || ctrl_load) && !i_sleep_request;
        selected  = !i_select_first_n && i_select_second_hi
                    && !i_select_third_n;
    end

    // Next state, address and burst counter
    always_comb begin
        state_nxt  = state_r;
        base_nxt   = base_r;
        start_nxt  = start_r;
        beat_nxt   = beat_r;
        asleep_nxt = i_sleep_request;
        if (i_sleep_request) begin
            state_nxt = ssp_pkg::SSP_DESELECTED;
        end else if (load) begin
            // Selects only matter on a load edge
            if (selected) begin
                state_nxt = ssp_pkg::SSP_SELECTED;
                base_nxt  = i_addr[`SSP_ADDR_W-1:`SSP_BASE_LSB];
                start_nxt = i_addr[`SSP_BEAT_W-1:0];
                beat_nxt  = `SSP_BEAT_RST;
            end else begin
                state_nxt = ssp_pkg::SSP_DESELECTED;
            end
        end else if (state_r == ssp_pkg::SSP_SELECTED
                     && !i_burst_advance_n) begin
            beat_nxt = beat_r + 2'h1;
        end
    end

    // Write decode; a processor load edge ignores the write inputs
    always_comb begin
        wr_req = !i_all_bytes_write_n
                 || (!i_byte_write_gate_n && !(&i_byte_lane_select_n));
        wr_lanes = `SSP_LANES_NONE;
        if (state_nxt == ssp_pkg::SSP_SELECTED && !proc_load
            && !i_sleep_request && wr_req) begin
            if (!i_all_bytes_write_n) begin
                wr_lanes = `SSP_LANES_ALL;
            end else if (!i_byte_write_gate_n) begin
                wr_lanes = ~i_byte_lane_select_n;
            end
        end
    end

    // Write and read addresses
    always_comb begin
        wr_beat = load ? `SSP_BEAT_RST : beat_r;
        wr_addr = {base_nxt, beat_bits(order, start_nxt, wr_beat)};
        rd_addr = {base_nxt, beat_bits(order, start_nxt, beat_nxt)};
    end

    // Lane packing: parity bit sits above its data byte
    always_comb begin
        for (int l = 0; l < `SSP_LANES; l++) begin
            wr_word[l*`SSP_LANE_W +: `SSP_LANE_W] =
                {i_parity_pins[l],
                 i_dq[l*`SSP_BYTE_W +: `SSP_BYTE_W]};
            o_dq[l*`SSP_BYTE_W +: `SSP_BYTE_W] =
                rd_word[l*`SSP_LANE_W +: `SSP_BYTE_W];
            o_parity_pins[l] =
                rd_word[l*`SSP_LANE_W + `SSP_BYTE_W];
        end
    end

    // Pin drive decision for the cycle after this edge
    always_comb begin
        oe_nxt = (state_nxt == ssp_pkg::SSP_SELECTED)
                 && !(|wr_lanes)
                 && !(load && selected
                      && state_r == ssp_pkg::SSP_DESELECTED)
                 && !i_out_enable_n
                 && !i_sleep_request;
    end

    // State registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r  <= ssp_pkg::SSP_DESELECTED;
            base_r   <= `SSP_BASE_RST;
            start_r  <= `SSP_START_RST;
            beat_r   <= `SSP_BEAT_RST;
            oe_r     <= 1'b0;
            asleep_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            base_r   <= base_nxt;
            start_r  <= start_nxt;
            beat_r   <= beat_nxt;
            oe_r     <= oe_nxt;
            asleep_r <= asleep_nxt;
        end
    end

    // Storage: pins captured on write edges, read word registered once
    ssp_mem ssp_mem_i (
        .i_clk      (i_clk),
        .i_resetn   (i_resetn),
        .i_wr_lanes (wr_lanes),
        .i_wr_addr  (wr_addr),
        .i_wr_word  (wr_word),
        .i_rd_addr  (rd_addr),
        .o_rd_word  (rd_word)
    );

    // Output enables from the drive flop
    assign o_dq_oe          = oe_r;
    assign o_parity_pins_oe = oe_r;
    assign o_asleep         = asleep_r;

endmodule

// ---- test/ssp_host_model.sv ----
// Bus master model driving the burst memory port pins
`timescale 1ns/10ps
module ssp_host_model (
    // Clock and device outputs
    input  wire logic        i_clk,
    input  wire logic [15:0] i_dq_out,
    input  wire logic [1:0]  i_par_out,
    input  wire logic        i_dq_oe,
    // Pins toward the device
    output logic      [18:0] o_addr,
    output logic      [9:0]  o_ctl,
    output logic      [1:0]  o_lanes_n,
    output logic      [17:0] o_line
);
    logic [17:0] drv, last;
    logic        de;
    // Line level: device, else master, else a value that keeps moving
    assign o_line = i_dq_oe ? {i_par_out, i_dq_out} : (de ? drv : ~last);
    always @(posedge i_clk) last <= o_line;
    initial begin
        o_ctl = 10'h0FC;
        o_lanes_n = 2'h3;
        o_addr = 19'h00000;
        drv = 18'h00000;
        de = 1'b0;
        last = 18'h00000;
    end
    // One bus cycle; returns what the previous cycle produced
    task automatic cyc(input logic [9:0] k, input logic [1:0] l,
        input logic [18:0] a, input logic [17:0] d,
        output logic oe, output logic [17:0] rd);
        @(posedge i_clk);
        o_ctl <= k;
        o_lanes_n <= l;
        o_addr <= a;
        drv <= d;
        de <= !k[4] || !k[3];
        #1;
        oe = i_dq_oe;
        rd = {i_par_out, i_dq_out};
    endtask
endmodule

// ---- test/ssp_port_properties.sv ----
// Pin-level assertions for the burst memory port
`timescale 1ns/10ps
module ssp_port_properties (
    // Clock, reset and strobes
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_proc_addr_strobe_n,
    input wire logic        i_ctrl_addr_strobe_n,
    input wire logic        i_burst_advance_n,
    // Selects and controls
    input wire logic        i_select_first_n,
    input wire logic        i_select_second_hi,
    input wire logic        i_select_third_n,
    input wire logic        i_all_bytes_write_n,
    input wire logic        i_byte_write_gate_n,
    input wire logic        i_out_enable_n,
    input wire logic        i_sleep_request,
    // Observed outputs
    input wire logic [15:0] o_dq,
    input wire logic        o_dq_oe,
    input wire logic        o_parity_pins_oe,
    input wire logic        o_asleep
);
    logic ld, ok, wr, sel_r, sel_nxt;
    // Load edge, select match and write intent as decoded at the pins
    assign ld = !i_sleep_request && ((!i_proc_addr_strobe_n &&
        !i_select_first_n) || (!i_ctrl_addr_strobe_n && i_proc_addr_strobe_n));
    assign ok = !i_select_first_n && i_select_second_hi && !i_select_third_n;
    assign wr = !i_all_bytes_write_n || !i_byte_write_gate_n;
    assign sel_nxt = i_sleep_request ? 1'b0 : (ld ? ok : sel_r);
    // Selected state tracked from the pins alone
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    AST_DESEL: assert property (ld && !ok |=> !o_dq_oe)
        else $error("pins driven after a deselecting load");
    AST_FIRST: assert property (ld && ok && !sel_r |=> !o_dq_oe)
        else $error("pins driven on first clock after deselection");
    AST_OE_OFF: assert property (i_out_enable_n |=> !o_dq_oe)
        else $error("pins driven with output enable high");
    AST_WRITE: assert property (i_proc_addr_strobe_n
        && !i_all_bytes_write_n |=> !o_dq_oe)
        else $error("pins driven during write data");
    AST_SLEEP: assert property (i_sleep_request
        |=> o_asleep && !o_dq_oe)
        else $error("sleep not entered");
    AST_PAR_OE: assert property (o_parity_pins_oe == o_dq_oe)
        else $error("parity direction differs from data");
    AST_KEEP: assert property (sel_r && !ld && !i_sleep_request
        && !i_out_enable_n && !wr |=> o_dq_oe)
        else $error("selects acted on without a load");
    AST_HOLD: assert property (sel_r && !ld && i_burst_advance_n
        && !wr && !i_sleep_request && o_dq_oe |=> $stable(o_dq))
        else $error("data moved without advance");
    // Main scenarios reached
    COV_FIRST: cover property (ld && ok && !sel_r);
    COV_ADV: cover property (sel_r && !ld && !i_burst_advance_n);
    COV_SLEEP: cover property (i_sleep_request);
endmodule
bind ssp_port ssp_port_properties ssp_port_properties_i (.i_clk, .i_resetn,
    .i_proc_addr_strobe_n, .i_ctrl_addr_strobe_n, .i_burst_advance_n,
    .i_select_first_n, .i_select_second_hi, .i_select_third_n,
    .i_all_bytes_write_n, .i_byte_write_gate_n, .i_out_enable_n,
    .i_sleep_request, .o_dq, .o_dq_oe, .o_parity_pins_oe, .o_asleep);

// ---- test/ssp_port_tb.sv ----
// Self-checking bench for the burst memory port
`timescale 1ns/10ps
module ssp_port_tb;
    localparam logic [18:0] BASE = 19'h00100;
    logic        clk, rstn, ord, oe, dq_oe, asl;
    logic [18:0] a;
    logic [9:0]  c;
    logic [1:0]  ls, par;
    logic [17:0] line, rd, sh [4];
    logic [15:0] dq;
    int          mismatches, n_checks, cycles;
    ssp_port ssp_port_i (.i_clk(clk), .i_resetn(rstn), .i_addr(a),
        .i_proc_addr_strobe_n(c[7]), .i_ctrl_addr_strobe_n(c[6]),
        .i_burst_advance_n(c[5]), .i_all_bytes_write_n(c[4]),
        .i_byte_write_gate_n(c[3]), .i_select_first_n(c[2]),
        .i_select_second_hi(c[1]), .i_select_third_n(c[0]),
        .i_byte_lane_select_n(ls), .i_out_enable_n(c[9]),
        .i_sleep_request(c[8]), .i_burst_order(ord), .i_dq(line[15:0]),
        .o_dq(dq), .o_dq_oe(dq_oe), .i_parity_pins(line[17:16]),
        .o_parity_pins(par), .o_parity_pins_oe(), .o_asleep(asl));
    ssp_host_model ssp_host_model_i (.i_clk(clk), .i_dq_out(dq),
        .i_par_out(par), .i_dq_oe(dq_oe), .o_addr(a), .o_ctl(c),
        .o_lanes_n(ls), .o_line(line));
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [9:0] k, input logic [1:0] l = 2'h3,
        input logic [17:0] d = 18'h00000);
        ssp_host_model_i.cyc(k, l, BASE + 19'(k[0]), d, oe, rd);
    endtask
    task automatic wr(input int i, input logic [1:0] l, input logic [9:0] k,
        input logic [17:0] d);
        ssp_host_model_i.cyc(k, l, BASE + 19'(i), d, oe, rd);
        for (int j = 0; j < 2; j++) if (!l[j] || !k[4]) begin
            sh[i][8*j +: 8] = d[8*j +: 8];
            sh[i][16+j] = d[16+j];
        end
    endtask
    // Global, lane and empty writes over one aligned group
    task automatic t_write();
        for (int i = 0; i < 4; i++) begin
            wr(i, 2'h3, 10'h0AA, 18'h25AC3 ^ 18'(i * 18'h0F111));
        end
        // Processor load with pins released, then writes on burst beats
        op(10'h27A);
        wr(0, 2'h3, 10'h0CA, 18'h2D2D2);
        wr(1, 2'h1, 10'h0D2, 18'h34B4B);
        wr(1, 2'h2, 10'h0B2, 18'h1C3C3);
        op(10'h2B2, 2'h3, 18'h3FFFF);
        op(10'h02A, 2'h3, 18'h0F0F0);
        op(10'h0BE);
        $display("write test done");
    endtask
    // Burst read from deselected state, then hold, stray strobe, oe off
    task automatic t_burst(input logic o, input logic [1:0] s);
        logic [1:0] b;
        @(posedge clk);
        ord <= o;
        ssp_host_model_i.cyc(10'h07A, 2'h3, BASE + 19'(s), 18'h0, oe, rd);
        for (int n = 0; n < 5; n++) begin
            op(n < 4 ? 10'h0DD : 10'h0FA);
            b = o ? s ^ 2'(n) : s + 2'(n);
            chk(rd, sh[b]);
            chk(18'(oe), 18'(n != 0));
        end
        op(10'h07E);
        chk(rd, sh[s]);
        op(10'h2FA);
        chk(18'(oe), 18'h1);
        op(10'h0BE);
        chk(18'(oe), 18'h0);
        $display("burst test done");
    endtask
    // Each wrong select pattern deselects the port
    task automatic t_desel();
        logic [9:0] k [3] = '{10'h0BE, 10'h0B8, 10'h0BB};
        foreach (k[j]) begin
            op(10'h07A);
            op(k[j]);
            op(10'h0FA);
            chk(18'(oe), 18'h0);
            op(10'h0FC);
            chk(18'(oe), 18'h0);
        end
        $display("select test done");
    endtask
    // Sleep blocks a load, then wakes
    task automatic t_sleep();
        op(10'h17A);
        op(10'h0FC);
        chk(18'(asl), 18'h1);
        op(10'h0FA);
        chk(18'(asl), 18'h0);
        op(10'h0FC);
        chk(18'(oe), 18'h0);
        $display("sleep test done");
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        ord = 1'b1;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_write();
        t_burst(1'b1, 2'h1);
        t_burst(1'b0, 2'h2);
        t_burst(1'b0, 2'h3);
        t_burst(1'b1, 2'h2);
        t_desel();
        t_sleep();
        t_burst(1'b1, 2'h1);
        print_verdict();
    end
endmodule
